// ---- hdl/acr_map.svh ----
// Purpose: Register indices, field positions and timing figures of the converter control block
// Assumes: Included by its bare name wherever the numbers are needed
// Notes: Byte address of a register is four times its index
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ACR_IDX_CSR 8'h36
`define ACR_IDX_HIGH 8'h37
`define ACR_IDX_LOW 8'h38

// ----------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------
`define ACR_CSR_DONE 7
`define ACR_CSR_RATE_HI 6
`define ACR_CSR_ON 5
`define ACR_CSR_CHAN_HI 3
`define ACR_CSR_CHAN_LO 0
`define ACR_CSR_RESET 8'h00

// ----------------------------------------------------------------
// Low data fields
// ----------------------------------------------------------------
`define ACR_LOW_QUARTER 3
`define ACR_LOW_RES_HI 1
`define ACR_LOW_RES_LO 0

// ----------------------------------------------------------------
// Result split and channels
// ----------------------------------------------------------------
`define ACR_RES_MSB 9
`define ACR_RES_HIGH_LSB 2
`define ACR_NUM_CHAN 10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACR_CLK_PERIOD_NS 50
`define ACR_STAB_NS 1000
`define ACR_DIV_HALF_LAST 1'b1
`define ACR_DIV_QUARTER_LAST 2'h3

`endif

// ---- hdl/acr_pkg.sv ----
// Purpose: Shared types of the converter control block
// Assumes: Used by scoped names only
// Notes: Constants live in acr_map.svh
package acr_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BUSY = 2'b10
	} acr_state_e;

	typedef logic [3:0] acr_chan_t;

endpackage

// ---- hdl/acr_clk_if.sv ----
// Purpose: Carries clock selection and the converter clock strobe between modules
// Assumes: Both ends clocked by pclk
// Notes: tick is a one-cycle strobe
`timescale 1ns/1ps
interface acr_clk_if;
	logic rate_hi;
	logic quarter;
	logic tick;

	modport ctl (output rate_hi, output quarter, input tick);
	modport gen (input rate_hi, input quarter, output tick);
endinterface

// ---- hdl/acr_clkgen.sv ----
// Purpose: Derives the converter clock strobe from the core clock
// Assumes: pclk is the core clock; ce freezes the divider
// Notes: Strobe rate is full, half or quarter of pclk
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_clkgen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	acr_clk_if.gen cif
);

	logic [1:0] div_q;
	logic [1:0] div_d;
	logic half_hit;
	logic quarter_hit;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	assign div_d = div_q + 2'h1;
	assign half_hit = (div_q[0] == `ACR_DIV_HALF_LAST);
	assign quarter_hit = (div_q == `ACR_DIV_QUARTER_LAST);

	// Quarter wins over the high-rate select
	assign cif.tick = ce & (cif.quarter ? quarter_hit :
		(cif.rate_hi ? 1'b1 : half_hit));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'h0;
		end else if (ce) begin
			div_q <= div_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_FULL_RATE: assert property (@(posedge pclk) disable iff (!presetn)
		ce && cif.rate_hi && !cif.quarter |-> cif.tick)
		else $error("full rate strobe missing");

	AST_QUARTER_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		ce && cif.tick && cif.quarter ##1 (ce && cif.quarter) |-> !cif.tick)
		else $error("quarter rate strobe too close");

	AST_HALF_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		ce && cif.tick && !cif.quarter && !cif.rate_hi
		##1 (ce && !cif.quarter && !cif.rate_hi) |-> !cif.tick)
		else $error("half rate strobe too close");

endmodule

// ---- hdl/acr_top.sv ----
// Purpose: APB register front end and sequencer for a 10-bit converter core
// Assumes: Inputs synchronous to pclk; the analog core converts on request
// Notes: Results above or below the references are saturated by the core itself
`timescale 1ns/1ps
`include "acr_map.svh"

// Contract
// - Done flag sets at conversion end; high read or status write clears it.
// - High-rate select bit is software read/write in control/status bit 6.
// - Quarter-rate select bit is software read/write in low data bit 3.
// - Clock: both low half, high-rate alone full, quarter select quarter.
// - Converter runs while the on bit is set; only software changes it.
// - Channel field codes zero to nine route inputs zero to nine.
// - High data register shows result bits 9 to 2, read only.
// - Low data register bits 1 and 0 show result bits 1 and 0.
// - Low data bits 7 to 4 and bit 2 always read zero.
// - Reset clears control/status: converter off, input zero, half rate.
// - With converter on, conversions repeat continuously, updating the result each time.
// - Channel change aborts conversion, clears done flag, restarts on new channel.
// - Overrange gives all ones, underrange zero, with no overflow flag.
// - Halt disables the converter; a stabilisation wait follows wakeup.
module acr_top #(
	parameter int ADDR_W = 12,
	parameter int STAB_NS = `ACR_STAB_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_mode,
	output logic adc_enable,
	output logic [3:0] adc_chan,
	output logic [`ACR_NUM_CHAN-1:0] adc_mux_sel,
	output logic adc_start,
	output logic adc_abort,
	output logic converter_clock_en,
	input wire logic adc_done,
	input wire logic [9:0] adc_result
);

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int STAB_CYC_I = (STAB_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS;
	localparam int STAB_CYC_C = (STAB_CYC_I < 1) ? 1 : STAB_CYC_I;
	localparam logic [15:0] STAB_CYC = 16'(STAB_CYC_C);
	localparam logic [7:0] CSR_RST = `ACR_CSR_RESET;
	localparam logic [ADDR_W-1:0] ADDR_CSR = ADDR_W'({`ACR_IDX_CSR, 2'b00});
	localparam logic [ADDR_W-1:0] ADDR_HIGH = ADDR_W'({`ACR_IDX_HIGH, 2'b00});
	localparam logic [ADDR_W-1:0] ADDR_LOW = ADDR_W'({`ACR_IDX_LOW, 2'b00});

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic done_q;
	logic done_d;
	logic rate_hi_q;
	logic on_q;
	acr_pkg::acr_chan_t chan_q;
	logic quarter_q;
	logic [7:0] res_high_q;
	logic [1:0] res_low_q;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [15:0] stab_q;
	logic [15:0] stab_d;
	acr_pkg::acr_state_e st_q;
	acr_pkg::acr_state_e st_d;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic hit_csr;
	logic hit_high;
	logic hit_low;
	logic hit_any;
	logic setup;
	logic access;
	logic wr_csr;
	logic wr_low;
	logic rd_high;
	logic chan_chg;
	logic [7:0] csr_view;
	logic [7:0] low_view;
	logic [7:0] rd_mux;

	assign hit_csr = (paddr == ADDR_CSR);
	assign hit_high = (paddr == ADDR_HIGH);
	assign hit_low = (paddr == ADDR_LOW);
	assign hit_any = hit_csr | hit_high | hit_low;
	assign setup = ce & psel & ~penable;
	assign access = ce & psel & penable;
	assign wr_csr = access & pwrite & hit_csr;
	assign wr_low = access & pwrite & hit_low;
	assign rd_high = access & ~pwrite & hit_high;
	assign chan_chg = wr_csr & (pwdata[`ACR_CSR_CHAN_HI:`ACR_CSR_CHAN_LO] != chan_q);

	// Reserved bit 4 reads zero whatever is written
	assign csr_view = {done_q, rate_hi_q, on_q, 1'b0, chan_q};
	assign low_view = {4'h0, quarter_q, 1'b0, res_low_q};
	assign rd_mux = hit_csr ? csr_view :
		hit_high ? res_high_q :
		hit_low ? low_view : 8'h00;
	assign prdata_d = setup ? {24'h000000, rd_mux} : prdata_q;

	// Zero wait states; read data is latched in the setup cycle
	assign pready = access;
	assign pslverr = access & ~hit_any;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_hi_q <= CSR_RST[`ACR_CSR_RATE_HI];
			on_q <= CSR_RST[`ACR_CSR_ON];
			chan_q <= CSR_RST[`ACR_CSR_CHAN_HI:`ACR_CSR_CHAN_LO];
		end else if (wr_csr) begin
			rate_hi_q <= pwdata[`ACR_CSR_RATE_HI];
			on_q <= pwdata[`ACR_CSR_ON];
			chan_q <= pwdata[`ACR_CSR_CHAN_HI:`ACR_CSR_CHAN_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quarter_q <= 1'b0;
		end else if (wr_low) begin
			quarter_q <= pwdata[`ACR_LOW_QUARTER];
		end
	end

	// ----------------------------------------------------------------
	// Converter clock
	// ----------------------------------------------------------------
	acr_clk_if cif ();

	assign cif.rate_hi = rate_hi_q;
	assign cif.quarter = quarter_q;
	assign converter_clock_en = cif.tick;

	acr_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.cif(cif)
	);

	// ----------------------------------------------------------------
	// Wakeup stabilisation
	// ----------------------------------------------------------------
	logic stab_zero;
	logic conv_run;

	assign stab_zero = (stab_q == 16'h0000);
	// Held at full count during halt, counts down after wakeup
	assign stab_d = halt_mode ? STAB_CYC : (stab_zero ? stab_q : stab_q - 16'h0001);
	assign conv_run = on_q & ~halt_mode & stab_zero;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stab_q <= 16'h0000;
		end else if (ce) begin
			stab_q <= stab_d;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	logic done_acc;

	// A done arriving with a channel change belongs to the old channel
	assign done_acc = adc_done & (st_q == acr_pkg::ST_BUSY) & conv_run & ~chan_chg;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			acr_pkg::ST_IDLE: begin
				if (conv_run) begin
					st_d = acr_pkg::ST_START;
				end
			end
			acr_pkg::ST_START: begin
				if (!conv_run) begin
					st_d = acr_pkg::ST_IDLE;
				end else if (!chan_chg) begin
					st_d = acr_pkg::ST_BUSY;
				end
			end
			acr_pkg::ST_BUSY: begin
				if (!conv_run) begin
					st_d = acr_pkg::ST_IDLE;
				end else if (chan_chg || done_acc) begin
					st_d = acr_pkg::ST_START;
				end
			end
			default: begin
				st_d = acr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= acr_pkg::ST_IDLE;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign adc_enable = on_q & ~halt_mode;
	assign adc_start = ce & (st_q == acr_pkg::ST_START) & conv_run & ~chan_chg;
	assign adc_abort = ce & (st_q == acr_pkg::ST_BUSY) & (chan_chg | ~conv_run);
	assign adc_chan = chan_q;

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `ACR_NUM_CHAN; gi = gi + 1) begin : g_mux
			assign adc_mux_sel[gi] = adc_enable & (chan_q == 4'(gi));
		end
	endgenerate

	// ----------------------------------------------------------------
	// Results and done flag
	// ----------------------------------------------------------------
	// Core value passes unchanged, saturation included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_high_q <= 8'h00;
			res_low_q <= 2'h0;
		end else if (ce && done_acc) begin
			res_high_q <= adc_result[`ACR_RES_MSB:`ACR_RES_HIGH_LSB];
			res_low_q <= adc_result[`ACR_LOW_RES_HI:`ACR_LOW_RES_LO];
		end
	end

	// Set wins over clear
	assign done_d = done_acc ? 1'b1 :
		((wr_csr | rd_high | chan_chg) ? 1'b0 : done_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= CSR_RST[`ACR_CSR_DONE];
		end else if (ce) begin
			done_q <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_DONE_SET: assert property (ce && done_acc |=> done_q)
		else $error("done flag not set at conversion end");

	AST_DONE_CLR: assert property (ce && rd_high && !done_acc |=> !done_q)
		else $error("done flag not cleared by high read");

	AST_CHAN_RESTART: assert property (
		chan_chg && on_q && !halt_mode && stab_zero |=> !done_q && st_q == acr_pkg::ST_START)
		else $error("channel change did not restart conversion");

	AST_RESULT_PAIR: assert property (ce && done_acc |=>
		res_high_q == $past(adc_result[9:2]) && res_low_q == $past(adc_result[1:0]))
		else $error("result halves not loaded together");

	AST_LOW_ZERO: assert property (setup && hit_low && !pwrite |=>
		prdata[7:4] == 4'h0 && prdata[2] == 1'b0 && prdata[1:0] == $past(res_low_q))
		else $error("low register reserved bits not zero");

	AST_CONTINUOUS: assert property (ce && done_acc |=> st_q == acr_pkg::ST_START)
		else $error("conversion did not repeat");

	AST_NEXT_START: assert property (
		ce && st_q == acr_pkg::ST_START && conv_run && !chan_chg |-> adc_start ##1 st_q == acr_pkg::ST_BUSY)
		else $error("start strobe missing");

	AST_HALT_OFF: assert property (halt_mode |-> !adc_enable && !adc_start && adc_mux_sel == '0)
		else $error("converter active during halt");

	AST_WAKE_WAIT: assert property ($fell(halt_mode) |-> !adc_start [*2])
		else $error("conversion started before stabilisation");

	AST_MUX_ROUTE: assert property (adc_enable && chan_q == 4'h9 |-> adc_mux_sel[9] && $onehot(adc_mux_sel))
		else $error("input nine not routed");

	AST_ABORT_CHAN: assert property (ce && st_q == acr_pkg::ST_BUSY && chan_chg |-> adc_abort)
		else $error("channel change did not abort conversion");

	AST_ABORT_OFF: assert property (ce && st_q == acr_pkg::ST_BUSY && !conv_run |-> adc_abort)
		else $error("switch off did not abort conversion");

	AST_ON_OFF: assert property (!on_q |-> !adc_enable && !adc_start && adc_mux_sel == '0)
		else $error("converter active while switched off");

	AST_CE_FREEZE: assert property (!ce |=>
		$stable(on_q) && $stable(chan_q) && $stable(done_q) && $stable(st_q))
		else $error("state moved while clock enable low");

	AST_DONE_WR_CLR: assert property (wr_csr && !done_acc |=> !done_q)
		else $error("done flag not cleared by status write");

	AST_RATE_SET: assert property (wr_csr && pwdata[`ACR_CSR_RATE_HI] |=> rate_hi_q)
		else $error("high-rate select not set");

	AST_RATE_CLR: assert property (wr_csr && !pwdata[`ACR_CSR_RATE_HI] |=> !rate_hi_q)
		else $error("high-rate select not cleared");

	AST_QUARTER_SET: assert property (wr_low && pwdata[`ACR_LOW_QUARTER] |=> quarter_q)
		else $error("quarter-rate select not set");

	AST_QUARTER_CLR: assert property (wr_low && !pwdata[`ACR_LOW_QUARTER] |=> !quarter_q)
		else $error("quarter-rate select not cleared");

	AST_HIGH_VIEW: assert property (setup && hit_high && !pwrite |=>
		prdata == {24'h000000, $past(res_high_q)})
		else $error("high register read wrong");

	AST_RESULT_HOLD: assert property (!(ce && done_acc) |=>
		$stable(res_high_q) && $stable(res_low_q))
		else $error("result changed outside conversion end");

endmodule

// ---- bench/acr_core_model.sv ----
// Purpose: Behavioural analog converter core facing the control block
// Assumes: lat of one or more cycles; level already clamped to the reference span
// Notes: Result bus toggles to garbage outside the done cycle
`timescale 1ns/1ps
module acr_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire logic adc_abort,
	input wire logic [9:0] level,
	input wire logic [7:0] lat,
	output logic adc_done,
	output logic [9:0] adc_result
);
	logic busy_q;
	logic [7:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			adc_done <= 1'b0;
			adc_result <= 10'h155;
		end else begin
			adc_done <= 1'b0;
			adc_result <= ~adc_result;
			if (adc_abort) begin
				busy_q <= 1'b0;
			end else if (adc_start) begin
				busy_q <= 1'b1;
				cnt_q <= lat;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b0;
				adc_done <= 1'b1;
				adc_result <= level;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// ---- bench/acr_top_test.sv ----
// Purpose: Self-checking bench of the converter control block
// Assumes: Zero-wait APB slave; core model in acr_core_model
// Notes: Stabilisation wait shortened to ten cycles
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_top_test;
	localparam logic [11:0] A_CSR = {2'b00, `ACR_IDX_CSR, 2'b00};
	localparam logic [11:0] A_HI = {2'b00, `ACR_IDX_HIGH, 2'b00};
	localparam logic [11:0] A_LO = {2'b00, `ACR_IDX_LOW, 2'b00};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic halt_mode = 1'b0;
	logic [9:0] level = 10'h000;
	logic [7:0] lat = 8'h1e;
	logic [31:0] prdata;
	logic pready, pslverr, adc_enable, adc_start, adc_abort, converter_clock_en, adc_done;
	logic [3:0] adc_chan;
	logic [9:0] adc_mux_sel, adc_result;
	int mismatches = 0;
	int check_count = 0;
	int starts = 0;
	int aborts = 0;
	int ticks = 0;

	always #25 pclk = ~pclk;

	acr_top #(.ADDR_W(12), .STAB_NS(500)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
		.adc_enable(adc_enable), .adc_chan(adc_chan), .adc_mux_sel(adc_mux_sel),
		.adc_start(adc_start), .adc_abort(adc_abort), .converter_clock_en(converter_clock_en),
		.adc_done(adc_done), .adc_result(adc_result));

	acr_core_model core (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
		.adc_abort(adc_abort), .level(level), .lat(lat), .adc_done(adc_done),
		.adc_result(adc_result));

	// ----------------------------------------------------------------
	// Event counters
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (adc_start === 1'b1) starts <= starts + 1;
		if (adc_abort === 1'b1) aborts <= aborts + 1;
		if (converter_clock_en === 1'b1) ticks <= ticks + 1;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 50) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask

	task automatic wait_done();
		logic [31:0] q;
		logic e;
		int n;
		q = 32'h0;
		for (n = 0; n < 100 && q[7] !== 1'b1; n++) apb(1'b0, A_CSR, 32'h0, q, e);
		if (q[7] !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		chk({22'h0, adc_mux_sel}, 32'h0);
		chk({31'h0, adc_enable}, 32'h0);
		rd(A_CSR, 32'h0);
		rd(A_LO, 32'h0);
		apb(1'b0, 12'h0e4, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_regs();
		lat <= 8'hc8;
		wr(A_CSR, 8'hef);
		rd(A_CSR, 32'h6f);
		chk({22'h0, adc_mux_sel}, 32'h0);
		wr(A_LO, 8'hff);
		rd(A_LO, 32'h08);
		wr(A_HI, 8'hff);
		rd(A_HI, 32'h0);
		wr(A_LO, 8'h00);
		wr(A_CSR, 8'h00);
		rd(A_CSR, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_chan();
		int c;
		for (c = 0; c < `ACR_NUM_CHAN; c++) begin
			wr(A_CSR, 8'h20 | 8'(c));
			chk({22'h0, adc_mux_sel}, 32'h1 << c);
			chk({28'h0, adc_chan}, 32'(c));
			chk({31'h0, adc_enable}, 32'h1);
		end
		wr(A_CSR, 8'h00);
		chk({31'h0, adc_enable}, 32'h0);
		$display("test chan done");
	endtask

	task automatic t_clock();
		int i;
		int t0;
		for (i = 0; i < 4; i++) begin
			wr(A_CSR, {1'b0, i[0], 1'b1, 5'h0});
			wr(A_LO, {4'h0, i[1], 3'h0});
			t0 = ticks;
			repeat (40) @(posedge pclk);
			chk(32'(ticks - t0), i[1] ? 32'd10 : (i[0] ? 32'd40 : 32'd20));
		end
		wr(A_LO, 8'h00);
		$display("test clock done");
	endtask

	task automatic t_convert();
		lat <= 8'h1e;
		level <= 10'h2d6;
		wr(A_CSR, 8'h23);
		wait_done();
		level <= 10'h3ff;
		rd(A_LO, 32'h02);
		rd(A_HI, 32'hb5);
		rd(A_CSR, 32'h23);
		wait_done();
		level <= 10'h000;
		rd(A_LO, 32'h03);
		rd(A_HI, 32'hff);
		wait_done();
		wr(A_CSR, 8'h23);
		rd(A_CSR, 32'h23);
		rd(A_HI, 32'h0);
		$display("test convert done");
	endtask

	task automatic t_abort();
		int a0;
		int s0;
		lat <= 8'h64;
		wr(A_CSR, 8'h21);
		repeat (3) @(posedge pclk);
		a0 = aborts;
		s0 = starts;
		wr(A_CSR, 8'h22);
		repeat (3) @(posedge pclk);
		chk(32'(aborts - a0), 32'h1);
		chk(32'(starts - s0), 32'h1);
		rd(A_CSR, 32'h22);
		$display("test abort done");
	endtask

	task automatic t_halt();
		int s0;
		halt_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({31'h0, adc_enable}, 32'h0);
		chk({22'h0, adc_mux_sel}, 32'h0);
		s0 = starts;
		halt_mode <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(32'(starts - s0), 32'h0);
		repeat (30) @(posedge pclk);
		chk(32'(starts - s0), 32'h1);
		$display("test halt done");
	endtask

	task automatic t_freeze();
		int t0;
		int s0;
		ce <= 1'b0;
		@(posedge pclk);
		t0 = ticks;
		s0 = starts;
		repeat (20) @(posedge pclk);
		chk(32'(ticks - t0), 32'h0);
		chk(32'(starts - s0), 32'h0);
		ce <= 1'b1;
		@(posedge pclk);
		rd(A_CSR, 32'h22);
		$display("test freeze done");
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_regs();
		t_chan();
		t_clock();
		t_convert();
		t_abort();
		t_halt();
		t_freeze();
		give_verdict();
	end
endmodule
